/* File: logic/accumulator_product_datapath.sv */
module accumulator_product_datapath (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic op_valid,
	input wire datapath_pkg::op_t op,
	input wire logic [15:0] operand16,
	input wire logic [31:0] operand32,
	input wire logic [31:0] operand32_b,
	input wire logic [7:0] imm8,
	input wire logic [3:0] imm_count_minus1,
	input wire logic [2:0] store_shift,
	input wire logic high_half_select,
	input wire logic sign_ext_mode,
	output logic [31:0] accumulator_32,
	output logic [31:0] product,
	output logic [31:0] multiplicand_register,
	output logic [2:0] product_shift_mode,
	output logic [5:0] overflow_counter,
	output logic test_flag,
	output logic zero_flag,
	output logic negative_flag,
	output logic [15:0] store_data16,
	output logic [31:0] store_data32,
	output logic store16_valid,
	output logic store32_valid
);
	// =====================================================
	// operand views
	logic [15:0] multiplicand_high;
	logic [4:0] count5;
	logic [3:0] count4;
	logic [5:0] count6;
	logic [4:0] imm_count;
	logic [63:0] pair;
	logic signed [31:0] product_shifted;
	logic [32:0] add_sum;
	logic add_overflow;

	assign multiplicand_high = multiplicand_register[31:16];
	assign count5 = multiplicand_high[4:0]; // RL1 RL3 RL25
	assign count4 = multiplicand_high[3:0]; // RL2 RL25
	assign count6 = multiplicand_high[5:0]; // RL5 RL25
	// encoded minus one so that all sixteen distances fit four bits
	assign imm_count = {1'b0, imm_count_minus1} + 5'h01; // RL4 RL6
	assign pair = {accumulator_32, product};

	// =====================================================
	// product shifter: mode 0 doubles, 1 passes, 2..7 shift right 1..6
	always_comb begin
		if (product_shift_mode == datapath_pkg::pm_shift_left_one) begin
			product_shifted = signed'({product[30:0], 1'b0}); // RL17
		end else begin
			product_shifted = signed'(product) >>>
				(product_shift_mode - datapath_pkg::pm_no_shift); // RL17
		end
	end

	assign add_sum = {1'b0, accumulator_32} + {1'b0, operand32};
	assign add_overflow = (accumulator_32[31] == operand32[31]) &&
		(add_sum[31] != accumulator_32[31]);

	// =====================================================
	// multipliers
	logic signed [33:0] mult_a;
	logic signed [33:0] mult_b;
	logic signed [67:0] mult_full;
	logic signed [31:0] dual_high;
	logic signed [31:0] dual_low;
	logic signed [24:0] byte_product;

	always_comb begin
		mult_a = {{2{operand32[31]}}, operand32};
		mult_b = {{2{multiplicand_register[31]}}, multiplicand_register};
		case (op)
			datapath_pkg::op_unsigned_mult_high_half: begin
				mult_a = {2'b00, operand32}; // RL20
				mult_b = {2'b00, multiplicand_register}; // RL20
			end
			datapath_pkg::op_mixed_mult_high_half: begin
				mult_a = {2'b00, operand32}; // RL20
			end
			default: begin
			end
		endcase
	end

	assign mult_full = mult_a * mult_b;
	assign dual_high = signed'(operand32[31:16]) *
		signed'(operand32_b[31:16]); // RL21
	assign dual_low = signed'(operand32[15:0]) *
		signed'(operand32_b[15:0]); // RL21
	assign byte_product = signed'(multiplicand_high) *
		signed'({1'b0, imm8}); // RL18

	// =====================================================
	// next-state selection
	logic [31:0] next_acc;
	logic [31:0] next_product;
	logic [31:0] next_multiplicand;
	logic [63:0] next_pair;
	logic [63:0] pair_shift;
	logic [31:0] store_shifted;
	logic [5:0] next_ovc;
	logic next_tc;
	logic acc_written;

	assign store_shifted = accumulator_32 << store_shift; // RL11

	always_comb begin
		next_acc = accumulator_32;
		next_product = product;
		next_multiplicand = multiplicand_register;
		next_pair = pair;
		pair_shift = pair;
		next_ovc = overflow_counter;
		next_tc = test_flag;
		acc_written = 1'b1;
		case (op)
			datapath_pkg::op_acc_arith_shift_right_var:
				next_acc = signed'(accumulator_32) >>> count5; // RL1
			datapath_pkg::op_acc_shift_left_short_var:
				next_acc = accumulator_32 << count4; // RL2
			datapath_pkg::op_acc_logic_shift_right_var:
				next_acc = accumulator_32 >> count5; // RL3
			datapath_pkg::op_acc_logic_shift_left_var:
				next_acc = accumulator_32 << count5; // RL3
			datapath_pkg::op_acc_shift_right: begin
				if (sign_ext_mode) begin
					next_acc = signed'(accumulator_32) >>> imm_count; // RL4
				end else begin
					next_acc = accumulator_32 >> imm_count; // RL4
				end
			end
			datapath_pkg::op_pair_arith_shift_right_var: begin
				pair_shift = signed'(pair) >>> count6; // RL5
				next_acc = pair_shift[63:32];
				next_product = pair_shift[31:0];
			end
			datapath_pkg::op_pair_logic_shift_left_var: begin
				pair_shift = pair << count6; // RL5
				next_acc = pair_shift[63:32];
				next_product = pair_shift[31:0];
			end
			datapath_pkg::op_pair_logic_shift_right_imm: begin
				pair_shift = pair >> imm_count; // RL6
				next_acc = pair_shift[63:32];
				next_product = pair_shift[31:0];
			end
			datapath_pkg::op_conditional_negate: begin
				if (test_flag) begin
					next_acc = 32'h00000000 - accumulator_32; // RL7
				end
			end
			datapath_pkg::op_absolute_with_flag: begin
				next_tc = accumulator_32[31]; // RL8
				if (accumulator_32[31]) begin
					next_acc = 32'h00000000 - accumulator_32; // RL8
				end
			end
			datapath_pkg::op_saturate_acc: begin
				// counter records net wraps; its sign picks the rail
				if (!overflow_counter[5] && overflow_counter != 6'h00) begin
					next_acc = datapath_pkg::sat_max; // RL9
				end else if (overflow_counter[5]) begin
					next_acc = datapath_pkg::sat_min; // RL9
				end
				next_ovc = 6'h00;
			end
			datapath_pkg::op_saturate_pair: begin
				if (!overflow_counter[5] && overflow_counter != 6'h00) begin
					next_pair = datapath_pkg::saturate_pair_max; // RL9
				end else if (overflow_counter[5]) begin
					next_pair = datapath_pkg::saturate_pair_min; // RL9
				end
				next_acc = next_pair[63:32];
				next_product = next_pair[31:0];
				next_ovc = 6'h00;
			end
			datapath_pkg::op_rounding_high_load:
				next_acc = {operand16, datapath_pkg::round_half}; // RL10
			datapath_pkg::op_unsigned_acc_load:
				next_acc = {16'h0000, operand16}; // RL12
			datapath_pkg::op_sign_extend_low_load: begin
				acc_written = 1'b0;
				next_multiplicand = {{16{operand16[15]}}, operand16}; // RL13
			end
			datapath_pkg::op_clear_multiplicand_low: begin
				acc_written = 1'b0;
				next_multiplicand = {multiplicand_high, 16'h0000}; // RL14
			end
			datapath_pkg::op_store_and_reload_multiplicand: begin
				acc_written = 1'b0;
				next_multiplicand = operand32; // RL15
			end
			datapath_pkg::op_load_mult_add_product: begin
				next_multiplicand = {operand16, multiplicand_register[15:0]};
				next_acc = accumulator_32 + 32'(product_shifted); // RL16
			end
			datapath_pkg::op_load_mult_sub_product: begin
				next_multiplicand = {operand16, multiplicand_register[15:0]};
				next_acc = accumulator_32 - 32'(product_shifted); // RL16
			end
			datapath_pkg::op_load_mult_move_product: begin
				next_multiplicand = {operand16, multiplicand_register[15:0]};
				next_acc = 32'(product_shifted); // RL16
			end
			datapath_pkg::op_add_long: begin
				next_acc = add_sum[31:0];
				if (add_overflow) begin
					// count up on positive wrap, down on negative wrap
					next_ovc = accumulator_32[31] ? overflow_counter - 6'h01 :
						overflow_counter + 6'h01; // RL24
				end
			end
			datapath_pkg::op_add_shifted_product:
				next_acc = accumulator_32 + 32'(product_shifted); // RL17
			datapath_pkg::op_byte_constant_multiply: begin
				acc_written = 1'b0;
				next_product = 32'(byte_product); // RL18
			end
			datapath_pkg::op_signed_mult_low_half: begin
				acc_written = 1'b0;
				next_product = high_half_select ? mult_full[63:32] :
					mult_full[31:0]; // RL19
			end
			datapath_pkg::op_signed_mult_high_half: begin
				acc_written = 1'b0;
				next_product = mult_full[63:32]; // RL19
			end
			datapath_pkg::op_unsigned_mult_high_half,
			datapath_pkg::op_mixed_mult_high_half: begin
				acc_written = 1'b0;
				next_product = mult_full[63:32]; // RL20
			end
			datapath_pkg::op_dual_multiply_accumulate: begin
				next_acc = accumulator_32 + dual_high; // RL21
				next_product = product + dual_low; // RL21
			end
			datapath_pkg::op_load_overflow_counter: begin
				acc_written = 1'b0;
				next_ovc = operand16[5:0];
			end
			datapath_pkg::op_test_acc: begin
				next_acc = accumulator_32; // RL22
			end
			default: acc_written = 1'b0;
		endcase
	end

	// =====================================================
	// architectural registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			accumulator_32 <= 32'h00000000;
		end else if (op_valid) begin
			accumulator_32 <= next_acc;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			product <= 32'h00000000;
		end else if (op_valid) begin
			product <= next_product;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			multiplicand_register <= 32'h00000000;
		end else if (op_valid) begin
			multiplicand_register <= next_multiplicand;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			product_shift_mode <= datapath_pkg::pm_reset;
		end else if (op_valid &&
			op == datapath_pkg::op_load_product_shift_mode) begin
			product_shift_mode <= operand16[2:0]; // RL23
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			overflow_counter <= 6'h00;
		end else if (op_valid) begin
			overflow_counter <= next_ovc; // RL9 RL24
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			test_flag <= 1'b0;
		end else if (op_valid) begin
			test_flag <= next_tc; // RL8
		end
	end

	// =====================================================
	// status flags follow the value each acc-writing op produced
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			zero_flag <= 1'b0;
		end else if (op_valid && acc_written) begin
			zero_flag <= (next_acc == 32'h00000000); // RL22 RL24
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			negative_flag <= 1'b0;
		end else if (op_valid && acc_written) begin
			negative_flag <= next_acc[31]; // RL24
		end
	end

	// =====================================================
	// store port; the old multiplicand leaves on the same edge the reload lands
	// data follows every cycle; only the valid pulse marks a real store
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			store_data16 <= 16'h0000;
			store16_valid <= 1'b0;
		end else begin
			store16_valid <= op_valid &&
				(op == datapath_pkg::op_store_shifted_low_word ||
				op == datapath_pkg::op_store_shifted_high_word); // RL11
			if (op == datapath_pkg::op_store_shifted_high_word) begin
				store_data16 <= store_shifted[31:16]; // RL11
			end else begin
				store_data16 <= store_shifted[15:0]; // RL11
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			store_data32 <= 32'h00000000;
			store32_valid <= 1'b0;
		end else begin
			store32_valid <= op_valid &&
				op == datapath_pkg::op_store_and_reload_multiplicand; // RL15
			store_data32 <= multiplicand_register; // RL15
		end
	end
endmodule : accumulator_product_datapath

/* File: logic/datapath_pkg.sv */
// Functional notes
// [RL1] 32-bit arithmetic right shift by register uses multiplicand high bits 4:0.
// [RL2] short left shift by register uses multiplicand high bits 3:0 only.
// [RL3] 32-bit logical right/left shifts by register use multiplicand high 4:0.
// [RL4] immediate accumulator right shift covers one to sixteen positions.
// [RL5] pair shifts by register use a six-bit count from multiplicand high.
// [RL6] immediate pair logical right shift covers one to sixteen positions.
// [RL7] conditional negate negates the accumulator only when test flag is one.
// [RL8] absolute with flag writes absolute value and loads test flag together.
// [RL9] saturate clamps accumulator or pair according to overflow counter.
// [RL10] rounding load clears low half, loads high half from operand, rounds.
// [RL11] shifted stores emit low or high word of accumulator shifted up to 7.
// [RL12] unsigned load puts operand in low half, zeros in high half.
// [RL13] sign-extend load writes multiplicand low half, sign bits above.
// [RL14] clear-low zeros multiplicand low half, keeps high half.
// [RL15] store-and-reload emits old multiplicand, then loads new 32-bit value.
// [RL16] load-multiplicand variants add, subtract or move product into acc.
// [RL17] accumulate-product adds product shifted by product shift mode.
// [RL18] byte multiply: multiplicand high signed, 8-bit immediate unsigned.
// [RL19] signed 32x32 multiply returns low or high 32 bits by variant.
// [RL20] unsigned and signed-by-unsigned 32x32 multiplies return high half.
// [RL21] dual multiply-accumulate: two 16x16 products into acc and product.
// [RL22] accumulator test reports all-zero without changing the accumulator.
// [RL23] product shift mode is three bits, loaded from low bits of a half.
// [RL24] status flags follow each operation's own definition.
// [RL25] register shift counts ignore bits above their field width.
package datapath_pkg;
	typedef enum logic [5:0] {
		op_nop = 6'h00, op_acc_arith_shift_right_var = 6'h01,
		op_acc_shift_left_short_var = 6'h02,
		op_acc_logic_shift_right_var = 6'h03,
		op_acc_logic_shift_left_var = 6'h04, op_acc_shift_right = 6'h05,
		op_pair_arith_shift_right_var = 6'h06,
		op_pair_logic_shift_left_var = 6'h07,
		op_pair_logic_shift_right_imm = 6'h08, op_conditional_negate = 6'h09,
		op_absolute_with_flag = 6'h0a, op_saturate_acc = 6'h0b,
		op_saturate_pair = 6'h0c, op_rounding_high_load = 6'h0d,
		op_store_shifted_low_word = 6'h0e, op_store_shifted_high_word = 6'h0f,
		op_unsigned_acc_load = 6'h10, op_sign_extend_low_load = 6'h11,
		op_clear_multiplicand_low = 6'h12,
		op_store_and_reload_multiplicand = 6'h13,
		op_load_mult_add_product = 6'h14, op_load_mult_sub_product = 6'h15,
		op_load_mult_move_product = 6'h16, op_add_long = 6'h17,
		op_add_shifted_product = 6'h18, op_byte_constant_multiply = 6'h19,
		op_signed_mult_low_half = 6'h1a, op_signed_mult_high_half = 6'h1b,
		op_unsigned_mult_high_half = 6'h1c, op_mixed_mult_high_half = 6'h1d,
		op_dual_multiply_accumulate = 6'h1e, op_test_acc = 6'h1f,
		op_load_product_shift_mode = 6'h20, op_load_overflow_counter = 6'h21
	} op_t;
	localparam int acc_width = 32;
	localparam int half_width = 16;
	localparam int pm_width = 3;
	localparam int ovc_width = 6;
	localparam int count5_width = 5;
	localparam int count4_width = 4;
	localparam int count6_width = 6;
	localparam int store_shift_width = 3;
	localparam int imm_count_width = 4;
	localparam logic [15:0] round_half = 16'h8000;
	localparam logic [31:0] sat_max = 32'h7fffffff;
	localparam logic [31:0] sat_min = 32'h80000000;
	localparam logic [63:0] saturate_pair_max = 64'h7fffffffffffffff;
	localparam logic [63:0] saturate_pair_min = 64'h8000000000000000;
	localparam logic [2:0] pm_reset = 3'h0;
	localparam logic [2:0] pm_shift_left_one = 3'h0;
	localparam logic [2:0] pm_no_shift = 3'h1;
endpackage : datapath_pkg

/* File: testbench/accumulator_product_datapath_test.sv */
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
	mismatches++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
// ====================
// bench top
module accumulator_product_datapath_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, hs, sx;
	logic [31:0] b32;
	logic [7:0] i8;
	logic [3:0] ic;
	logic [2:0] ss;
	wire datapath_pkg::op_t op;
	wire logic ov, tf, zf, nf, sv16, sv32;
	wire logic [15:0] o16, sd16;
	wire logic [31:0] o32, a32, prod, mult, sd32;
	wire logic [2:0] psm;
	wire logic [5:0] ocnt;
	int mismatches;
	int total_checks;
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	op_feeder i_op_feeder (.clk(clk), .op_valid(ov), .op(op),
		.operand16(o16), .operand32(o32));
	accumulator_product_datapath i_accumulator_product_datapath (
		.clk(clk), .rst_n(rst_n), .op_valid(ov), .op(op), .operand16(o16),
		.operand32(o32), .operand32_b(b32), .imm8(i8), .imm_count_minus1(ic),
		.store_shift(ss), .high_half_select(hs), .sign_ext_mode(sx),
		.accumulator_32(a32), .product(prod), .multiplicand_register(mult),
		.product_shift_mode(psm), .overflow_counter(ocnt), .test_flag(tf),
		.zero_flag(zf), .negative_flag(nf), .store_data16(sd16),
		.store_data32(sd32), .store16_valid(sv16), .store32_valid(sv32));
	task go(input datapath_pkg::op_t c, input logic [15:0] a,
		input logic [31:0] b);
		i_op_feeder.issue(c, a, b);
	endtask : go
	task set_a32(input logic [31:0] v);
		go(datapath_pkg::op_unsigned_acc_load, 16'h0000, 32'h0);
		go(datapath_pkg::op_add_long, 16'h0000, v);
	endtask : set_a32
	task t_shifts;
		// low bits 0x35: five give 21, four give 5, six give 53
		go(datapath_pkg::op_store_and_reload_multiplicand, 0, 32'h00350000);
		set_a32(32'h80000000);
		go(datapath_pkg::op_acc_arith_shift_right_var, 0, 0);
		`CHK(a32, 32'hfffffc00)
		set_a32(32'h80000000);
		go(datapath_pkg::op_acc_logic_shift_right_var, 0, 0);
		`CHK(a32, 32'h00000400)
		set_a32(32'h1);
		go(datapath_pkg::op_acc_logic_shift_left_var, 0, 0);
		`CHK(a32, 32'h00200000)
		set_a32(32'h1);
		go(datapath_pkg::op_acc_shift_left_short_var, 0, 0);
		`CHK(a32, 32'h00000020)
		set_a32(32'h80000000);
		go(datapath_pkg::op_signed_mult_low_half, 0, 0);
		go(datapath_pkg::op_pair_arith_shift_right_var, 0, 0);
		`CHK({a32, prod}, 64'hfffffffffffffc00)
		go(datapath_pkg::op_pair_logic_shift_left_var, 0, 0);
		`CHK({a32, prod}, 64'h8000000000000000)
		ic = 4'hf;
		go(datapath_pkg::op_pair_logic_shift_right_imm, 0, 0);
		`CHK({a32, prod}, 64'h0000800000000000)
		set_a32(32'h80000000);
		sx = 1'b1;
		go(datapath_pkg::op_acc_shift_right, 0, 0);
		`CHK(a32, 32'hffff8000)
		sx = 1'b0;
		ic = 4'h0;
		go(datapath_pkg::op_acc_shift_right, 0, 0);
		`CHK(a32, 32'h7fffc000)
		$display("shift test done");
	endtask : t_shifts
	task t_sign;
		set_a32(32'hfffffffb);
		`CHK(nf, 1'b1)
		go(datapath_pkg::op_absolute_with_flag, 0, 0);
		`CHK({tf, a32}, 33'h100000005)
		go(datapath_pkg::op_conditional_negate, 0, 0);
		`CHK(a32, 32'hfffffffb)
		go(datapath_pkg::op_absolute_with_flag, 0, 0);
		go(datapath_pkg::op_absolute_with_flag, 0, 0);
		go(datapath_pkg::op_conditional_negate, 0, 0);
		`CHK({tf, a32}, 33'h000000005)
		set_a32(32'h7fffffff);
		go(datapath_pkg::op_add_long, 16'h0000, 32'h00000001);
		`CHK({ocnt, a32}, {6'h01, 32'h80000000})
		go(datapath_pkg::op_load_overflow_counter, 16'h0001, 0);
		go(datapath_pkg::op_saturate_acc, 0, 0);
		`CHK({ocnt, a32}, {6'h00, datapath_pkg::sat_max})
		go(datapath_pkg::op_load_overflow_counter, 16'h003f, 0);
		go(datapath_pkg::op_saturate_pair, 0, 0);
		`CHK({a32, prod}, datapath_pkg::saturate_pair_min)
		$display("sign test done");
	endtask : t_sign
	task t_loads;
		go(datapath_pkg::op_rounding_high_load, 16'h1234, 0);
		`CHK(a32, 32'h12348000)
		go(datapath_pkg::op_unsigned_acc_load, 16'hbeef, 0);
		`CHK(a32, 32'h0000beef)
		set_a32(32'h87654321);
		for (int s = 0; s < 8; s++) begin
			ss = 3'(s);
			go(datapath_pkg::op_store_shifted_low_word, 0, 0);
			`CHK({sv16, sd16}, {1'b1, 16'(32'h87654321 << s)})
			go(datapath_pkg::op_store_shifted_high_word, 0, 0);
			`CHK(sd16, 16'((32'h87654321 << s) >> 16))
		end
		go(datapath_pkg::op_sign_extend_low_load, 16'h8001, 0);
		`CHK(mult, 32'hffff8001)
		go(datapath_pkg::op_clear_multiplicand_low, 0, 0);
		`CHK(mult, 32'hffff0000)
		go(datapath_pkg::op_store_and_reload_multiplicand, 0, 32'h3);
		`CHK({sv32, sd32, mult}, {1'b1, 32'hffff0000, 32'h3})
		go(datapath_pkg::op_nop, 16'hffff, 32'hffffffff);
		`CHK({sv16, sv32, a32}, {2'b00, 32'h87654321})
		$display("load test done");
	endtask : t_loads
	task t_mult;
		go(datapath_pkg::op_load_product_shift_mode, 16'hfff9, 0);
		`CHK(psm, 3'h1)
		go(datapath_pkg::op_signed_mult_low_half, 0, 32'h5);
		`CHK(prod, 32'd15)
		set_a32(32'd100);
		go(datapath_pkg::op_load_mult_add_product, 16'h0007, 0);
		`CHK({mult[31:16], a32}, {16'h0007, 32'd115})
		go(datapath_pkg::op_load_mult_sub_product, 16'h0002, 0);
		`CHK(a32, 32'd100)
		go(datapath_pkg::op_load_mult_move_product, 16'h0001, 0);
		`CHK(a32, 32'd15)
		go(datapath_pkg::op_load_product_shift_mode, 16'h0000, 0);
		go(datapath_pkg::op_add_shifted_product, 0, 0);
		`CHK(a32, 32'd45)
		go(datapath_pkg::op_load_product_shift_mode, 16'h0003, 0);
		go(datapath_pkg::op_add_shifted_product, 0, 0);
		`CHK(a32, 32'd48)
		go(datapath_pkg::op_load_mult_move_product, 16'hfffe, 0);
		i8 = 8'hff;
		go(datapath_pkg::op_byte_constant_multiply, 0, 0);
		`CHK(prod, 32'hfffffe02)
		go(datapath_pkg::op_store_and_reload_multiplicand, 0, 32'hffffffff);
		go(datapath_pkg::op_signed_mult_low_half, 0, 32'h80000000);
		`CHK(prod, 32'h80000000)
		hs = 1'b1;
		go(datapath_pkg::op_signed_mult_low_half, 0, 32'h80000000);
		`CHK(prod, 32'h0)
		hs = 1'b0;
		go(datapath_pkg::op_signed_mult_high_half, 0, 32'h00000002);
		`CHK(prod, 32'hffffffff)
		go(datapath_pkg::op_unsigned_mult_high_half, 0, 32'h80000000);
		`CHK(prod, 32'h7fffffff)
		go(datapath_pkg::op_mixed_mult_high_half, 0, 32'h80000000);
		`CHK(prod, 32'hffffffff)
		go(datapath_pkg::op_load_product_shift_mode, 16'h0001, 0);
		go(datapath_pkg::op_signed_mult_low_half, 0, 0);
		set_a32(32'd10);
		b32 = 32'h00040005;
		go(datapath_pkg::op_dual_multiply_accumulate, 0, 32'h00020003);
		`CHK({a32, prod}, {32'd18, 32'd15})
		go(datapath_pkg::op_test_acc, 0, 0);
		`CHK({zf, a32}, {1'b0, 32'd18})
		go(datapath_pkg::op_unsigned_acc_load, 16'h0000, 0);
		go(datapath_pkg::op_test_acc, 0, 0);
		`CHK(zf, 1'b1)
		$display("multiply test done");
	endtask : t_mult
	task end_of_test;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test
	initial begin
		#40000;
		mismatches++;
		end_of_test;
	end
	initial begin
		mismatches = 0;
		total_checks = 0;
		{rst_n, hs, sx, b32, i8, ic, ss} = '0;
		repeat (12) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		t_shifts;
		t_sign;
		t_loads;
		t_mult;
		end_of_test;
	end
endmodule : accumulator_product_datapath_test

/* File: testbench/datapath_checker_asserts.sv */
// ====================
// port-level checks
module datapath_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic op_valid,
	input wire datapath_pkg::op_t op,
	input wire logic [15:0] operand16,
	input wire logic [31:0] operand32,
	input wire logic [2:0] store_shift,
	input wire logic [31:0] accumulator_32,
	input wire logic [31:0] multiplicand_register,
	input wire logic test_flag,
	input wire logic zero_flag,
	input wire logic [15:0] store_data16,
	input wire logic [31:0] store_data32,
	input wire logic store16_valid,
	input wire logic store32_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	hi_store_a: assert property (
		op_valid && op == datapath_pkg::op_store_shifted_high_word
		|=> store16_valid && store_data16 ==
		16'(($past(accumulator_32) << $past(store_shift)) >> 16))
		else $error("high store");
	neg_keep_a: assert property (
		op_valid && op == datapath_pkg::op_conditional_negate
		&& !test_flag
		|=> $stable(accumulator_32))
		else $error("negate without flag");
	neg_flip_a: assert property (
		op_valid && op == datapath_pkg::op_conditional_negate
		&& test_flag
		|=> accumulator_32 == -$past(accumulator_32))
		else $error("negate");
	uload_a: assert property (
		op_valid && op == datapath_pkg::op_unsigned_acc_load
		|=> accumulator_32 == {16'h0000, $past(operand16)})
		else $error("unsigned load");
	round_a: assert property (
		op_valid && op == datapath_pkg::op_rounding_high_load
		|=> accumulator_32 == {$past(operand16), 16'h8000})
		else $error("rounding load");
	sext_a: assert property (
		op_valid && op == datapath_pkg::op_sign_extend_low_load
		|=> multiplicand_register == 32'(signed'($past(operand16))))
		else $error("sign load");
	clr_low_a: assert property (
		op_valid && op == datapath_pkg::op_clear_multiplicand_low
		|=> multiplicand_register ==
		($past(multiplicand_register) & 32'hffff0000))
		else $error("clear low");
	reload_a: assert property (
		op_valid && op == datapath_pkg::op_store_and_reload_multiplicand
		|=> store32_valid && store_data32 == $past(multiplicand_register)
		&& multiplicand_register == $past(operand32))
		else $error("reload");
	acc_test_a: assert property (
		op_valid && op == datapath_pkg::op_test_acc
		|=> $stable(accumulator_32)
		&& zero_flag == ($past(accumulator_32) == 32'h00000000))
		else $error("zero test");
	cover property (op_valid && op == datapath_pkg::op_conditional_negate && test_flag);
	cover property (store16_valid);
	cover property (store32_valid);
endmodule : datapath_checker

bind accumulator_product_datapath datapath_checker i_datapath_checker (
	.clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op(op),
	.operand16(operand16), .operand32(operand32), .store_shift(store_shift),
	.accumulator_32(accumulator_32),
	.multiplicand_register(multiplicand_register), .test_flag(test_flag),
	.zero_flag(zero_flag), .store_data16(store_data16),
	.store_data32(store_data32), .store16_valid(store16_valid),
	.store32_valid(store32_valid)
);

/* File: testbench/op_feeder.sv */
// ====================
// decode and operand fetch stand-in
module op_feeder (
	input wire logic clk,
	output logic op_valid,
	output datapath_pkg::op_t op,
	output logic [15:0] operand16,
	output logic [31:0] operand32
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		op_valid = 1'b0;
		op = datapath_pkg::op_nop;
		operand16 = 16'h0000;
		operand32 = 32'h00000000;
	end
	// released operands are inverted so a stale value never looks valid
	task issue(input datapath_pkg::op_t c, input logic [15:0] a,
		input logic [31:0] b);
		@(negedge clk);
		op_valid = 1'b1;
		op = c;
		operand16 = a;
		operand32 = b;
		@(negedge clk);
		op_valid = 1'b0;
		operand16 = ~a;
		operand32 = ~b;
	endtask : issue
endmodule : op_feeder
